//--- src/cgc_pkg.sv
// Package for the clock generation and distribution block
package cgc_pkg;
   // Divider select codes, two bits each except the four-bit prescale
   localparam logic [3:0] CGC_PRESCALE_RST = 4'h0;
   localparam logic [1:0] CGC_PLL_DIV_RST  = 2'h0;
   localparam logic [1:0] CGC_BASE_DIV_RST = 2'h0;
   localparam logic [1:0] CGC_CPU_DIV_RST  = 2'h0;
   localparam logic [1:0] CGC_BUS_DIV_RST  = 2'h0;
   // Clock rates
   localparam int CGC_CLK_HZ   = 25000000;
   localparam int CGC_OCO_HZ   = 125000;
   // Half period of the on-chip oscillator in system clocks
   localparam int CGC_OCO_HALF = CGC_CLK_HZ / (2 * CGC_OCO_HZ);
   localparam logic [7:0] CGC_OCO_HALF_CNT = 8'(CGC_OCO_HALF - 1);
   localparam int CGC_QUARTER  = 4;

   typedef struct packed {
      logic [1:0] pll_div_sel;   // p = 2,4,6,8
      logic [3:0] prescale_n;    // n = 0..15
      logic [1:0] base_div_sel;  // b = 2,3,4,6
      logic [1:0] cpu_div_sel;   // m = 1..4
      logic [1:0] bus_div_sel;   // q = 2..4
      logic       base_source_select; // 0 = PLL
      logic       main_clock_stop;
   } cgc_cfg_t;

   typedef struct packed {
      logic sub_clock_ctrl_bit;
      logic wdt_source_onchip;
      logic prescaler_source_onchip;
   } cgc_oco_req_t;

   typedef enum logic [1:0] {
      CGC_OCO_OFF,
      CGC_OCO_RUN
   } cgc_oco_st_t;
endpackage

//--- src/cgc_clock_generation_control.sv
// Clock generation, division and wait-mode gating
`timescale 1ns/1ps
module cgc_clock_generation_control
   import cgc_pkg::*;
(
   // Clock, reset, enable
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         ce,
   // Source clock enables, one tick per source edge
   input  wire logic         pll_tick,
   input  wire logic         main_tick,
   // Configuration
   input  wire cgc_cfg_t     cfg,
   input  wire cgc_oco_req_t oco_req,
   input  wire logic         option_osc_stop_setting,
   input  wire logic         option_powerup_start_setting,
   input  wire logic         wait_mode,
   // Derived clocks as levels, plus status levels and the watchdog strobe
   output logic              pll_run,
   output logic              pll_div_clk,
   output logic              timer_clk,
   output logic              base_clk,
   output logic              cpu_clk,
   output logic              bus_clk,
   output logic              onchip_clk,
   output logic              onchip_quarter_clock,
   output logic              wdt_clk_en,
   output logic              oco_running
);
   // Ratio decode shared by the PLL, base, CPU and bus dividers
   function automatic logic [3:0] half_of(input logic [1:0] sel,
                                          input logic [1:0] kind);
      logic [3:0] r;
      r = 4'h1;
      unique case (kind)
         2'h0:
            unique case (sel)
               2'h0: r = 4'h2;
               2'h1: r = 4'h4;
               2'h2: r = 4'h6;
               2'h3: r = 4'h8;
            endcase
         2'h1:
            unique case (sel)
               2'h0: r = 4'h2;
               2'h1: r = 4'h3;
               2'h2: r = 4'h4;
               2'h3: r = 4'h6;
            endcase
         2'h2:
            unique case (sel)
               2'h0: r = 4'h1;
               2'h1: r = 4'h2;
               2'h2: r = 4'h3;
               2'h3: r = 4'h4;
            endcase
         default:
            unique case (sel)
               2'h0: r = 4'h2;
               2'h1: r = 4'h3;
               // Top code repeats the slowest bus ratio
               2'h2, 2'h3: r = 4'h4;
            endcase
      endcase
      return r;
   endfunction

   // Divider stage: toggles an output after ratio ticks per period.
   // Odd ratios use a duty near half; ratio loaded only at period end.
   logic [3:0] ratio_d [5];
   logic [4:0] tick_in;
   logic [4:0] clk_q;
   logic [4:0] period_end;
   logic [3:0] cnt_q [5];
   logic [3:0] rat_q [5];

   logic base_gate;
   assign base_gate = ~wait_mode;

   // Source oscillator keeps running regardless of wait mode
   logic pll_keep;
   assign pll_keep = ~cfg.main_clock_stop | ~cfg.base_source_select;

   logic base_src_tick;
   assign base_src_tick = cfg.base_source_select ? main_tick
                                                 : (pll_tick & pll_keep);

   assign ratio_d[0] = half_of(cfg.pll_div_sel, 2'h0);
   assign ratio_d[1] = half_of(cfg.base_div_sel, 2'h1);
   assign ratio_d[2] = half_of(cfg.cpu_div_sel, 2'h2);
   assign ratio_d[3] = half_of(cfg.bus_div_sel, 2'h3);
   assign ratio_d[4] = cfg.prescale_n;

   assign tick_in[0] = pll_tick & pll_keep;
   assign tick_in[1] = base_src_tick & base_gate;
   assign tick_in[2] = period_end[1];
   assign tick_in[3] = period_end[1];
   assign tick_in[4] = period_end[0];

   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_div
         logic [3:0] lim;
         logic       unity;
         logic       first_half;
         // Count ticks up to ratio, then close a full output period
         assign lim = (rat_q[g] == 4'h0) ? 4'h1 : rat_q[g];
         assign unity = (lim == 4'h1);
         assign period_end[g] = tick_in[g] & (cnt_q[g] == lim - 4'h1);
         // High for the first half of a period, rounded up
         assign first_half = (cnt_q[g] + 4'h1) <
                             ({1'b0, lim[3:1]} + {3'h0, lim[0]});
         always_ff @(posedge clk) begin
            if (srst) begin
               cnt_q[g] <= 4'h0;
               rat_q[g] <= 4'h1;
               clk_q[g] <= 1'b0;
            end else if (ce) begin
               if (tick_in[g] && period_end[g]) begin
                  cnt_q[g] <= 4'h0;
                  rat_q[g] <= ratio_d[g];
               end else if (tick_in[g]) begin
                  cnt_q[g] <= cnt_q[g] + 4'h1;
               end
               // Divide by one follows the tick, else it would stick high
               if (unity)
                  clk_q[g] <= tick_in[g];
               else if (tick_in[g])
                  clk_q[g] <= first_half | period_end[g];
            end
         end

         // Count and ratio invariants of each stage
         AST_CNT_RANGE: assert property (@(posedge clk) disable iff (srst)
            cnt_q[g] < lim)
            else $error("Divider count beyond its ratio");
         AST_RATIO_STEP: assert property (@(posedge clk) disable iff (srst)
            ce && !period_end[g] |=> $stable(rat_q[g]))
            else $error("Divider ratio changed mid period");
      end
   endgenerate

   // On-chip oscillator
   cgc_oco_st_t oco_st_q;
   logic        oco_start;
   logic        strap_seen_q;
   logic [7:0]  oco_cnt_q;
   logic        oco_q;
   logic [1:0]  quarter_q;
   logic        oco_edge;

   assign oco_start = |oco_req;
   assign oco_edge  = (oco_st_q == CGC_OCO_RUN) && (oco_cnt_q == CGC_OCO_HALF_CNT);

   always_ff @(posedge clk) begin
      if (srst) begin
         oco_st_q     <= CGC_OCO_OFF;
         strap_seen_q <= 1'b0;
      end else if (ce) begin
         strap_seen_q <= 1'b1;
         unique case (oco_st_q)
            CGC_OCO_OFF:
               if (!strap_seen_q) begin
                  if (!(option_osc_stop_setting &&
                        !option_powerup_start_setting))
                     oco_st_q <= CGC_OCO_RUN;
               end else if (oco_start) begin
                  oco_st_q <= CGC_OCO_RUN;
               end
            CGC_OCO_RUN: oco_st_q <= CGC_OCO_RUN;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         oco_cnt_q <= 8'h00;
         oco_q     <= 1'b0;
         quarter_q <= 2'h0;
      end else if (ce && oco_st_q == CGC_OCO_RUN) begin
         oco_cnt_q <= oco_edge ? 8'h00 : oco_cnt_q + 8'h01;
         if (oco_edge) begin
            oco_q <= ~oco_q;
            if (oco_q)
               quarter_q <= quarter_q + 2'h1;
         end
      end
   end

   // Output selection ahead of the output flops
   logic timer_next;
   logic wdt_on_oco;
   logic wdt_next;
   logic oco_on;

   // Zero prescale passes the divided PLL clock through
   assign timer_next = (cfg.prescale_n == 4'h0) ? clk_q[0] : clk_q[4];
   // Watchdog runs on bus clock unless an on-chip source
   assign wdt_on_oco = oco_req.wdt_source_onchip ||
                       oco_req.prescaler_source_onchip;
   assign wdt_next   = wdt_on_oco ? oco_edge : period_end[3];
   assign oco_on     = (oco_st_q == CGC_OCO_RUN);

   // Registered outputs
   always_ff @(posedge clk) begin
      if (srst) begin
         pll_run              <= 1'b0;
         pll_div_clk          <= 1'b0;
         timer_clk            <= 1'b0;
         base_clk             <= 1'b0;
         cpu_clk              <= 1'b0;
         bus_clk              <= 1'b0;
         onchip_clk           <= 1'b0;
         onchip_quarter_clock <= 1'b0;
         wdt_clk_en           <= 1'b0;
         oco_running          <= 1'b0;
      end else if (ce) begin
         pll_run              <= pll_keep;
         pll_div_clk          <= clk_q[0];
         timer_clk            <= timer_next;
         base_clk             <= clk_q[1];
         cpu_clk              <= clk_q[2];
         bus_clk              <= clk_q[3];
         onchip_clk           <= oco_q;
         onchip_quarter_clock <= quarter_q[1];
         wdt_clk_en           <= wdt_next;
         oco_running          <= oco_on;
      end
   end

   // Assertions
   AST_PLL_KEEP: assert property (@(posedge clk) disable iff (srst)
      ce && !cfg.base_source_select |=> pll_run)
      else $error("PLL stopped while selected");
   AST_WAIT_STOP: assert property (@(posedge clk) disable iff (srst)
      wait_mode |-> !period_end[1])
      else $error("Base clock ran in wait mode");
   AST_OCO_HOLD: assert property (@(posedge clk) disable iff (srst)
      $fell(srst) ##0 option_osc_stop_setting
      && !option_powerup_start_setting && !oco_start |=> !oco_running)
      else $error("On-chip oscillator ran after reset");
   AST_OCO_START: assert property (@(posedge clk) disable iff (srst)
      ce && strap_seen_q && oco_start |=> ##1 oco_running)
      else $error("On-chip oscillator did not start");
   AST_OCO_STAYS: assert property (@(posedge clk) disable iff (srst)
      oco_running |=> oco_running)
      else $error("On-chip oscillator stopped");
   AST_WDT_WAIT: assert property (@(posedge clk) disable iff (srst)
      ce && wait_mode && !oco_req.wdt_source_onchip
      && !oco_req.prescaler_source_onchip |=> !wdt_clk_en)
      else $error("Watchdog counted in wait mode");
   AST_OCO_WAIT: assert property (@(posedge clk) disable iff (srst)
      ce && oco_edge && wait_mode |=> ##1 onchip_clk != $past(onchip_clk))
      else $error("On-chip clock halted in wait mode");
   AST_RATIO_LOAD: assert property (@(posedge clk) disable iff (srst)
      ce && !period_end[1] |=> $stable(rat_q[1]))
      else $error("Base ratio changed mid period");

   // Wait mode gating of the derived clocks
   AST_BUS_WAIT: assert property (@(posedge clk) disable iff (srst)
      wait_mode |-> !period_end[2] && !period_end[3])
      else $error("CPU or bus clock ran in wait mode");
   AST_WDT_OCO: assert property (@(posedge clk) disable iff (srst)
      ce && wait_mode && wdt_on_oco && oco_edge |=> wdt_clk_en)
      else $error("Watchdog halted on on-chip source");

   // Prescaler bypass and on-chip divider
   AST_TIMER_PASS: assert property (@(posedge clk) disable iff (srst)
      ce && cfg.prescale_n == 4'h0 |=> timer_clk == $past(clk_q[0]))
      else $error("Timer clock not passed through");
   AST_OCO_IDLE: assert property (@(posedge clk) disable iff (srst)
      oco_st_q == CGC_OCO_OFF |-> oco_cnt_q == 8'h00 && !oco_q)
      else $error("On-chip counter moved while stopped");
   AST_HALF_RANGE: assert property (@(posedge clk) disable iff (srst)
      oco_cnt_q <= CGC_OCO_HALF_CNT)
      else $error("On-chip half period overrun");
   AST_QUARTER_STEP: assert property (@(posedge clk) disable iff (srst)
      ce && oco_edge && oco_q |=> quarter_q == $past(quarter_q) + 2'h1)
      else $error("Quarter divider missed a step");

   // Reset clears the status and strobe outputs
   AST_RESET_OUT: assert property (@(posedge clk)
      srst |=> !oco_running && !pll_run && !wdt_clk_en)
      else $error("Outputs not cleared by reset");

   COV_WAIT: cover property (@(posedge clk) wait_mode ##1 !wait_mode);
   COV_OCO: cover property (@(posedge clk) $rose(oco_running));
   COV_QUART: cover property (@(posedge clk) $rose(onchip_quarter_clock));
   COV_MAIN_SRC: cover property (@(posedge clk)
      cfg.base_source_select && period_end[1]);
   COV_WDT_WAIT: cover property (@(posedge clk) wait_mode && wdt_clk_en);
endmodule

//--- tb/cgc_clock_generation_control_tb.sv
// Self-checking bench for the clock generation block
`timescale 1ns/1ps
module cgc_clock_generation_control_tb;
   import cgc_pkg::*;
   typedef struct {
      logic [1:0] p, b, m, q;
      logic [3:0] n;
      logic       src;
      int         ep, et, eb, ec, eu;
   } cgc_row_t;
   logic         clk, srst, ce, pll_tick, main_tick, wait_mode;
   logic         osc_stop, pwr_start, pll_run, oco_running;
   cgc_cfg_t     cfg;
   cgc_oco_req_t oco_req;
   logic [7:0]   outs;
   int           bad_count, checks, per;
   cgc_row_t     rows [4];

   cgc_clock_generation_control i_dut (
      .clk(clk), .srst(srst), .ce(ce), .pll_tick(pll_tick),
      .main_tick(main_tick), .cfg(cfg), .oco_req(oco_req),
      .option_osc_stop_setting(osc_stop),
      .option_powerup_start_setting(pwr_start), .wait_mode(wait_mode),
      .pll_run(pll_run), .pll_div_clk(outs[0]), .timer_clk(outs[1]),
      .base_clk(outs[2]), .cpu_clk(outs[3]), .bus_clk(outs[4]),
      .onchip_clk(outs[5]), .onchip_quarter_clock(outs[6]),
      .wdt_clk_en(outs[7]), .oco_running(oco_running));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic stop_test();
      if (bad_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         $display("CHECK FAILED %s expected %0d seen %0d", name, exp, seen);
         bad_count++;
      end
   endtask

   task automatic tick();
      @(posedge clk);
      #1;
   endtask

   // Bounded wait for the next rising level of one derived clock
   task automatic rise(input int idx, inout int t);
      logic prev;
      prev = outs[idx];
      tick();
      t++;
      while (!(prev === 1'b0 && outs[idx] === 1'b1) && t < 2000) begin
         prev = outs[idx];
         tick();
         t++;
      end
      if (t >= 2000) begin
         bad_count++;
         stop_test();
      end
   endtask

   task automatic period(input int idx, output int p);
      int t, t0;
      t = 0;
      rise(idx, t);
      t0 = t;
      rise(idx, t);
      p = t - t0;
   endtask

   task automatic toggles(input int idx, input int n, output int c);
      logic prev;
      c = 0;
      prev = outs[idx];
      repeat (n) begin
         tick();
         if (outs[idx] !== prev) c++;
         prev = outs[idx];
      end
   endtask

   task automatic do_reset(input logic stop_s, input logic start_s);
      @(posedge clk);
      srst      <= 1'b1;
      osc_stop  <= stop_s;
      pwr_start <= start_s;
      oco_req   <= '0;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      tick();
   endtask

   initial begin
      srst = 1'b1; ce = 1'b1; pll_tick = 1'b1; main_tick = 1'b1;
      wait_mode = 1'b0; osc_stop = 1'b1; pwr_start = 1'b0;
      cfg = '0; oco_req = '0; bad_count = 0; checks = 0;
      rows[0] = '{2'h0, 2'h0, 2'h0, 2'h0, 4'h0, 1'b0, 2, 2, 2, 2, 4};
      rows[1] = '{2'h1, 2'h1, 2'h1, 2'h1, 4'h1, 1'b0, 4, 4, 3, 6, 9};
      rows[2] = '{2'h2, 2'h2, 2'h2, 2'h2, 4'hF, 1'b0, 6, 90, 4, 12, 16};
      rows[3] = '{2'h3, 2'h3, 2'h3, 2'h0, 4'h5, 1'b1, 8, 40, 6, 24, 12};
      repeat (2) @(posedge clk);
      #1;
      check("outs in reset", {outs, pll_run, oco_running}, 32'h0);
      srst <= 1'b0;
      cfg.main_clock_stop <= 1'b1;
      toggles(5, 300, per);
      check("onchip stopped", per, 0);
      check("oco_running", oco_running, 1'b0);
      check("pll_run", pll_run, 1'b1);
      // Each start bit needs its own reset, the oscillator never stops
      for (int i = 0; i < 3; i++) begin
         do_reset(1'b1, 1'b0);
         repeat (20) tick();
         check("oco before start", oco_running, 1'b0);
         @(posedge clk);
         oco_req <= cgc_oco_req_t'(3'h1 << i);
         repeat (3) tick();
         check("oco after start", oco_running, 1'b1);
         period(5, per);
         check("onchip period", per, 2 * (CGC_OCO_HALF));
      end
      period(6, per);
      check("quarter period", per, 8 * CGC_OCO_HALF);
      foreach (rows[i]) begin
         @(posedge clk);
         cfg.pll_div_sel        <= rows[i].p;
         cfg.base_div_sel       <= rows[i].b;
         cfg.cpu_div_sel        <= rows[i].m;
         cfg.bus_div_sel        <= rows[i].q;
         cfg.prescale_n         <= rows[i].n;
         cfg.base_source_select <= rows[i].src;
         // PLL may only be stopped when it is not the base source
         cfg.main_clock_stop    <= ~rows[i].src;
         repeat (300) tick();
         check("pll running", pll_run, 1'b1);
         period(0, per);
         check("pll div period", per, rows[i].ep);
         period(1, per);
         check("timer period", per, rows[i].et);
         period(2, per);
         check("base period", per, rows[i].eb);
         period(3, per);
         check("cpu period", per, rows[i].ec);
         period(4, per);
         check("bus period", per, rows[i].eu);
      end
      @(posedge clk);
      cfg <= '0;
      oco_req <= '{1'b0, 1'b1, 1'b0};
      wait_mode <= 1'b1;
      repeat (30) tick();
      for (int k = 2; k < 5; k++) begin
         toggles(k, 300, per);
         check("gated in wait", per, 0);
      end
      toggles(0, 100, per);
      check("pll div in wait", 32'(per > 0), 1);
      toggles(5, 500, per);
      check("onchip in wait", 32'(per > 0), 1);
      toggles(7, 1000, per);
      check("wdt on onchip", 32'(per > 0), 1);
      @(posedge clk);
      oco_req <= '0;
      repeat (10) tick();
      toggles(7, 1000, per);
      check("wdt stopped", per, 0);
      @(posedge clk);
      wait_mode <= 1'b0;
      do_reset(1'b0, 1'b0);
      repeat (5) tick();
      check("oco free start", oco_running, 1'b1);
      do_reset(1'b1, 1'b1);
      repeat (5) tick();
      check("oco powerup start", oco_running, 1'b1);
      stop_test();
   end
endmodule
